// File: core/tws_pkg.sv
// Shared constants and types for the two-wire pointer-access slave and its host.
// Summary of operation
// RL1 - Address upper four bits fixed at 0101.
// RL2 - Digitize address strap once after power-up.
// RL3 - Hold strapped bits; ignore later strap changes.
// RL4 - Top three converter bits form address low bits.
// RL5 - Data falling while clock high starts transfer.
// RL6 - Eight bits follow: address MSB first, direction.
// RL7 - Own address acknowledged low before ninth pulse.
// RL8 - Direction 0 writes, direction 1 reads.
// RL9 - Each byte takes nine pulses including acknowledge.
// RL10 - Data rising while clock high means stop.
// RL11 - Read ends with no-acknowledge, stop; slave releases.
// RL12 - Direction fixed per operation; new start to switch.
// RL13 - First written byte loads address pointer.
// RL14 - Second written byte goes to pointed register.
// RL15 - Writes carry one or two bytes only.
// RL16 - Read returns one byte from pointed register.
// RL17 - Unknown pointer: pointer write, then separate read.
// RL18 - Pointer persists across operations until rewritten.
// RL19 - Read data MSB first; start/stop abandons byte.
package tws_pkg;
	localparam logic [3:0] ADDR_HI = 4'h5; // Fixed upper address nibble
	localparam int LOW_W = 3; // Strapped address bits
	localparam int ADC_W = 8; // Converter code width
	localparam logic [7:0] PTR_RST = 8'h00; // Pointer after power-up
	localparam logic [3:0] LAST_DATA_BIT = 4'h7; // Index of eighth pulse
	localparam logic [3:0] ACK_BIT = 4'h8; // Index of ninth pulse
	localparam int CLK_NS = 50; // System clock period
	localparam int SCL_NS = 10000; // Generated link clock period
	localparam int QTR_CYC = (SCL_NS + 4 * CLK_NS - 1) / (4 * CLK_NS); // Cycles per quarter bit
	// Slave link-side states
	typedef enum logic [2:0] {
		LS_ADDR = 3'b000,
		LS_PTR = 3'b001,
		LS_DATA = 3'b010,
		LS_READ = 3'b011,
		LS_IDLE = 3'b100
	} tws_link_e;
	// Host sequencer states
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_START = 2'b01,
		HS_BYTE = 2'b10,
		HS_STOP = 2'b11
	} tws_host_e;
	// Strap capture states
	typedef enum logic [1:0] {
		AS_REQ = 2'b00,
		AS_WAIT = 2'b01,
		AS_HOLD = 2'b10
	} tws_strap_e;
endpackage : tws_pkg

// File: core/tws_if.sv
// Open-drain two-wire bus joining host and slave.
`timescale 1ns/100ps
interface tws_if;
	logic scl; // Link clock, driven by host
	logic sda_h_o; // Host data output value
	logic sda_h_oe; // Host pulls data low
	logic sda_s_o; // Slave data output value
	logic sda_s_oe; // Slave pulls data low
	logic sda; // Resolved data line
	// Pull-up wins unless an enabled low driver
	assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_s_oe & ~sda_s_o));
	modport host (
		output scl, sda_h_o, sda_h_oe,
		input sda
	);
	modport dev (
		input scl, sda,
		output sda_s_o, sda_s_oe
	);
endinterface : tws_if

// File: core/tws_addr_strap.sv
// Power-up capture of the strapped address bits through the converter.
`timescale 1ns/100ps
module tws_addr_strap import tws_pkg::*; #(
	parameter int AW = ADC_W, // Converter code width
	parameter int LW = LOW_W // Captured bits
) (
	input wire logic clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic ce, // Clock enable
	output logic adc_start, // One-cycle conversion request
	input wire logic adc_done, // Conversion finished pulse
	input wire logic [AW-1:0] adc_code, // Converter result
	output logic [LW-1:0] low_bits, // Held address low bits
	output logic strap_ok // Low bits valid
);
	typedef struct packed {
		tws_strap_e st;
		logic start;
		logic [LW-1:0] low;
		logic ok;
	} tws_strap_s;
	tws_strap_s sr_r; // Register copy
	tws_strap_s sr_nxt; // Next copy

	// Request once, then freeze forever
	always_comb begin
		sr_nxt = sr_r;
		sr_nxt.start = 1'b0;
		unique case (sr_r.st)
			AS_REQ: begin
				sr_nxt.start = 1'b1; // see RL2
				sr_nxt.st = AS_WAIT;
			end
			AS_WAIT: begin
				if (adc_done) begin
					sr_nxt.low = adc_code[AW-1 -: LW]; // see RL4
					sr_nxt.ok = 1'b1;
					sr_nxt.st = AS_HOLD;
				end
			end
			AS_HOLD: ; // Later strap changes ignored, see RL3
			default: sr_nxt.st = AS_HOLD;
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sr_r <= '{st: AS_REQ, default: '0};
		end else if (ce) begin
			sr_r <= sr_nxt;
		end
	end

	assign adc_start = sr_r.start;
	assign low_bits = sr_r.low;
	assign strap_ok = sr_r.ok;
endmodule : tws_addr_strap

// File: core/tws_slave.sv
// Two-wire slave end: framing on the link clock, register side on clk.
`timescale 1ns/100ps
module tws_slave import tws_pkg::*; #(
	parameter int AW = ADC_W // Converter code width
) (
	input wire logic clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic ce, // Clock enable, system side
	tws_if.dev bus, // Two-wire bus
	output logic adc_start, // Strap conversion request
	input wire logic adc_done, // Strap conversion done
	input wire logic [AW-1:0] adc_code, // Strap conversion code
	output logic [LOW_W-1:0] addr_low, // Captured address bits
	output logic [7:0] reg_ptr, // Address pointer
	output logic wr_stb, // Data register write pulse
	output logic [7:0] wr_data, // Data for pointed register
	input wire logic [7:0] rd_data // Pointed register contents
);
	// System-side state
	typedef struct packed {
		logic scl1; // Synchroniser first stages
		logic scl2;
		logic scl3; // Previous synced clock
		logic sda1;
		logic sda2;
		logic sda3; // Previous synced data
		logic p1; // Pointer-ready sync
		logic p2;
		logic p3;
		logic d1; // Data-ready sync
		logic d2;
		logic d3;
		logic frame_rst; // Holds link logic idle
		logic [7:0] ptr;
		logic wr_stb;
		logic [7:0] wr_data;
		logic [7:0] rd_hold; // Read word offered to link
	} tws_sys_s;

	// Link-side state, cleared at every start or stop
	typedef struct packed {
		tws_link_e st;
		logic [3:0] bitc; // Completed pulses in byte
		logic [7:0] sh; // Shift register
		logic oe; // Pulling data low
		logic [7:0] pbyte; // Received pointer byte
		logic [7:0] dbyte; // Received data byte
		logic p_rdy; // Pointer byte held
		logic d_rdy; // Data byte held
		logic av1; // Strap-valid sync
		logic av2;
	} tws_lnk_s;

	tws_sys_s cr_r; // System register copy
	tws_sys_s cr_nxt; // System next copy
	tws_lnk_s lr_r; // Link register copy
	tws_lnk_s lr_nxt; // Link next copy
	logic [LOW_W-1:0] low_bits; // Strapped bits
	logic strap_ok; // Strap captured
	logic start_c; // Start seen this cycle
	logic stop_c; // Stop seen this cycle
	logic rst_link_n; // Link-side reset
	logic [7:0] byte_in; // Byte completed at this edge
	logic [6:0] own_addr; // Our bus address

	// Strap captured once after power-up
	tws_addr_strap #(
		.AW(AW),
		.LW(LOW_W)
	) u_strap (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.adc_start(adc_start),
		.adc_done(adc_done),
		.adc_code(adc_code),
		.low_bits(low_bits),
		.strap_ok(strap_ok)
	);

	assign own_addr = {ADDR_HI, low_bits}; // see RL1

	// Start and stop seen from synced lines
	always_comb begin
		start_c = cr_r.scl2 & cr_r.scl3 & cr_r.sda3 & ~cr_r.sda2; // see RL5
		stop_c = cr_r.scl2 & cr_r.scl3 & ~cr_r.sda3 & cr_r.sda2; // see RL10
	end

	// System-side next state
	always_comb begin
		cr_nxt = cr_r;
		cr_nxt.scl1 = bus.scl;
		cr_nxt.scl2 = cr_r.scl1;
		cr_nxt.scl3 = cr_r.scl2;
		cr_nxt.sda1 = bus.sda;
		cr_nxt.sda2 = cr_r.sda1;
		cr_nxt.sda3 = cr_r.sda2;
		cr_nxt.p1 = lr_r.p_rdy;
		cr_nxt.p2 = cr_r.p1;
		cr_nxt.p3 = cr_r.p2;
		cr_nxt.d1 = lr_r.d_rdy;
		cr_nxt.d2 = cr_r.d1;
		cr_nxt.d3 = cr_r.d2;
		cr_nxt.wr_stb = 1'b0;
		cr_nxt.rd_hold = rd_data;
		// Condition resets link side until clock falls
		if (start_c || stop_c) begin
			cr_nxt.frame_rst = 1'b1; // see RL19
		end else if (!cr_r.scl2) begin
			cr_nxt.frame_rst = 1'b0;
		end
		// Pointer byte arrived: load pointer
		if (cr_r.p2 && !cr_r.p3) begin
			cr_nxt.ptr = lr_r.pbyte; // see RL13
		end
		// Data byte arrived: one write pulse
		if (cr_r.d2 && !cr_r.d3) begin
			cr_nxt.wr_stb = 1'b1; // see RL14
			cr_nxt.wr_data = lr_r.dbyte;
		end
	end

	// System-side register; pointer survives frames
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			// Line synchronisers start at the idle-high level: no false edge after reset
			cr_r <= '{frame_rst: 1'b1, scl1: 1'b1, scl2: 1'b1, scl3: 1'b1,
				sda1: 1'b1, sda2: 1'b1, sda3: 1'b1, ptr: PTR_RST, default: '0}; // see RL18
		end else if (ce) begin
			cr_r <= cr_nxt;
		end
	end

	// Link side sits in reset outside a frame
	assign rst_link_n = nrst & ~cr_r.frame_rst;

	// Link-side next state, evaluated at each falling clock
	always_comb begin
		lr_nxt = lr_r;
		lr_nxt.av1 = strap_ok;
		lr_nxt.av2 = lr_r.av1;
		byte_in = {lr_r.sh[6:0], bus.sda}; // see RL6
		if (lr_r.bitc == ACK_BIT) begin
			// End of acknowledge pulse: release line
			lr_nxt.bitc = 4'h0; // see RL9
			lr_nxt.oe = 1'b0;
			if (lr_r.st == LS_READ) begin
				// Load pointed word, first bit out
				lr_nxt.sh = cr_r.rd_hold; // see RL16
				lr_nxt.oe = ~cr_r.rd_hold[7]; // see RL19
			end
		end else begin
			lr_nxt.bitc = lr_r.bitc + 4'h1;
			if (lr_r.st == LS_READ) begin
				if (lr_r.bitc == LAST_DATA_BIT) begin
					// Byte sent: release for host no-acknowledge
					lr_nxt.oe = 1'b0; // see RL11
					lr_nxt.st = LS_IDLE; // see RL16
				end else begin
					// Next bit, most significant first
					lr_nxt.sh = {lr_r.sh[6:0], 1'b0};
					lr_nxt.oe = ~lr_r.sh[6]; // see RL19
				end
			end else begin
				lr_nxt.sh = byte_in;
				if (lr_r.bitc == LAST_DATA_BIT) begin
					unique case (lr_r.st)
						// Address byte: match, then pick direction
						LS_ADDR: begin
							if (lr_r.av2 && byte_in[7:1] == own_addr) begin
								lr_nxt.oe = 1'b1; // see RL7
								lr_nxt.st = byte_in[0] ? LS_READ : LS_PTR; // see RL8
							end else begin
								lr_nxt.st = LS_IDLE; // see RL7
							end
						end
						// First write byte: pointer
						LS_PTR: begin
							lr_nxt.oe = 1'b1;
							lr_nxt.pbyte = byte_in; // see RL13
							lr_nxt.p_rdy = 1'b1;
							lr_nxt.st = LS_DATA;
						end
						// Second write byte: data
						LS_DATA: begin
							lr_nxt.oe = 1'b1;
							lr_nxt.dbyte = byte_in; // see RL14
							lr_nxt.d_rdy = 1'b1;
							lr_nxt.st = LS_IDLE; // see RL15
						end
						// Not addressed or done: stay silent
						LS_IDLE: ; // see RL12
						default: lr_nxt.st = LS_IDLE;
					endcase
				end
			end
		end
	end

	// Link register; data sampled on the falling clock within hold time
	always_ff @(negedge bus.scl or negedge rst_link_n) begin
		if (!rst_link_n) begin
			lr_r <= '{st: LS_ADDR, default: '0}; // see RL5
		end else begin
			lr_r <= lr_nxt;
		end
	end

	// Open-drain drive and user outputs
	assign bus.sda_s_o = 1'b0;
	assign bus.sda_s_oe = lr_r.oe;
	assign addr_low = low_bits;
	assign reg_ptr = cr_r.ptr;
	assign wr_stb = cr_r.wr_stb;
	assign wr_data = cr_r.wr_data;
endmodule : tws_slave

// File: core/tws_host.sv
// Two-wire host end: generates the link clock and runs one operation per command.
`timescale 1ns/100ps
module tws_host import tws_pkg::*; #(
	parameter int QTR = QTR_CYC // System cycles per quarter bit
) (
	input wire logic clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic ce, // Clock enable
	tws_if.host bus, // Two-wire bus
	input wire logic cmd_valid, // Command offered
	output logic cmd_ready, // Command taken when high with valid
	input wire logic cmd_rd, // 1 read, 0 write
	input wire logic cmd_two, // Write carries data byte
	input wire logic [6:0] cmd_addr, // Slave address
	input wire logic [7:0] cmd_ptr, // Pointer byte
	input wire logic [7:0] cmd_data, // Data byte
	output logic rsp_valid, // One-cycle completion pulse
	output logic [7:0] rsp_data, // Read byte
	output logic rsp_nack // A byte went unacknowledged
);
	localparam logic [15:0] QMAX = 16'(QTR - 1); // Last count of a quarter

	typedef struct packed {
		tws_host_e st;
		logic [1:0] ph; // Quarter within bit
		logic [15:0] cnt; // Quarter timer
		logic [3:0] bitc; // Bit within byte
		logic [1:0] idx; // Byte within operation
		logic [7:0] sh; // Transmit shift
		logic [7:0] rx; // Receive shift
		logic rd;
		logic two;
		logic [7:0] ptr;
		logic [7:0] data;
		logic scl_o;
		logic oe;
		logic nack;
		logic s1; // Data-in synchroniser
		logic s2;
		logic rsp;
		logic [7:0] rsp_data;
	} tws_host_s;
	tws_host_s hr_r; // Register copy
	tws_host_s hr_nxt; // Next copy
	logic tick; // Quarter elapsed
	logic rxb; // Current byte is received
	logic last; // Current byte ends operation

	// Next state of the sequencer
	always_comb begin
		hr_nxt = hr_r;
		hr_nxt.s1 = bus.sda;
		hr_nxt.s2 = hr_r.s1;
		hr_nxt.rsp = 1'b0;
		tick = (hr_r.cnt == QMAX);
		rxb = hr_r.rd & (hr_r.idx == 2'h1);
		last = hr_r.nack | (hr_r.idx == 2'h2) | (hr_r.idx == 2'h1 & (hr_r.rd | ~hr_r.two));
		if (hr_r.st != HS_IDLE) begin
			hr_nxt.cnt = tick ? 16'h0 : hr_r.cnt + 16'h1;
			if (tick) begin
				hr_nxt.ph = hr_r.ph + 2'h1;
			end
		end
		unique case (hr_r.st)
			// Take a command
			HS_IDLE: begin
				if (cmd_valid) begin
					hr_nxt = '{st: HS_START, rd: cmd_rd, two: cmd_two, ptr: cmd_ptr,
						data: cmd_data, sh: {cmd_addr, cmd_rd}, scl_o: 1'b1,
						s1: hr_r.s1, s2: hr_r.s2, rsp_data: hr_r.rsp_data, default: '0};
				end
			end
			// Data falls with clock high, then clock falls
			HS_START: begin
				if (tick) begin
					if (hr_r.ph == 2'h0) begin
						hr_nxt.oe = 1'b1; // see RL5
					end else if (hr_r.ph == 2'h1) begin
						hr_nxt.scl_o = 1'b0;
					end else begin
						hr_nxt.st = HS_BYTE;
						hr_nxt.ph = 2'h0;
						hr_nxt.oe = ~hr_r.sh[7]; // see RL6
					end
				end
			end
			// Nine pulses per byte
			HS_BYTE: begin
				if (tick) begin
					unique case (hr_r.ph)
						2'h0: hr_nxt.scl_o = 1'b1;
						2'h1: begin
							if (hr_r.bitc != ACK_BIT) begin
								hr_nxt.rx = {hr_r.rx[6:0], hr_r.s2};
							end else if (!rxb) begin
								hr_nxt.nack = hr_r.s2;
							end
						end
						2'h2: hr_nxt.scl_o = 1'b0;
						2'h3: begin
							if (hr_r.bitc != ACK_BIT) begin
								hr_nxt.bitc = hr_r.bitc + 4'h1;
								hr_nxt.sh = {hr_r.sh[6:0], 1'b1};
								// Ack slot released; read byte ends in no-acknowledge, see RL11
								hr_nxt.oe = (hr_r.bitc != LAST_DATA_BIT) & ~rxb & ~hr_r.sh[6];
							end else if (last) begin
								hr_nxt.st = HS_STOP;
								hr_nxt.oe = 1'b1; // see RL11
							end else begin
								// One address, then pointer and optional data, or the read byte, see RL15
								hr_nxt.idx = hr_r.idx + 2'h1;
								hr_nxt.bitc = 4'h0;
								hr_nxt.sh = (hr_r.idx == 2'h0) ? (hr_r.rd ? 8'hFF : hr_r.ptr) : hr_r.data;
								hr_nxt.oe = ~hr_r.rd & ~((hr_r.idx == 2'h0) ? hr_r.ptr[7] : hr_r.data[7]);
							end
						end
					endcase
				end
			end
			// Clock rises, then data rises
			HS_STOP: begin
				if (tick) begin
					if (hr_r.ph == 2'h0) begin
						hr_nxt.scl_o = 1'b1;
					end else if (hr_r.ph == 2'h1) begin
						hr_nxt.oe = 1'b0; // see RL10
					end else begin
						hr_nxt.st = HS_IDLE; // see RL12
						hr_nxt.rsp = 1'b1;
						hr_nxt.rsp_data = hr_r.rx;
					end
				end
			end
		endcase
	end

	// Sequencer register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hr_r <= '{st: HS_IDLE, scl_o: 1'b1, s1: 1'b1, s2: 1'b1, default: '0};
		end else if (ce) begin
			hr_r <= hr_nxt;
		end
	end

	assign cmd_ready = (hr_r.st == HS_IDLE);
	assign bus.scl = hr_r.scl_o;
	assign bus.sda_h_o = 1'b0;
	assign bus.sda_h_oe = hr_r.oe;
	assign rsp_valid = hr_r.rsp;
	assign rsp_data = hr_r.rsp_data;
	assign rsp_nack = hr_r.nack;
endmodule : tws_host

// File: tb/tws_monitor.sv
// Bus-side checker for the two-wire host and slave pair.
`timescale 1ns/100ps
module tws_monitor import tws_pkg::*; (
	input wire logic clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic scl, // Link clock
	input wire logic sda, // Resolved data line
	input wire logic sda_s_o, // Slave data value
	input wire logic sda_s_oe, // Slave pull enable
	input wire logic [LOW_W-1:0] addr_low // Captured address bits
);
	logic scl_r; // Clock one sample back
	logic sda_r; // Data one sample back
	logic oe_r; // Slave enable one sample back
	logic dir_r; // Direction bit of frame
	logic frm_r; // Inside a frame
	logic [3:0] rc_r; // Rising edges in byte
	logic [3:0] byte_r; // Byte index in frame
	logic [7:0] sh_r; // Bits shifted in
	logic match; // Address byte names the slave
	logic ack8; // Clock low after eighth rise
	assign match = sh_r[7:1] == {ADDR_HI, addr_low};
	assign ack8 = rc_r == 4'h8 && !scl_r;
	// Track the bit position from the line itself
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{scl_r, sda_r, oe_r, dir_r, frm_r} <= 5'h18;
			{rc_r, byte_r, sh_r} <= 16'h0000;
		end else begin
			scl_r <= scl;
			sda_r <= sda;
			oe_r <= sda_s_oe;
			if (scl && scl_r && sda_r && !sda) begin // Start resets the count
				frm_r <= 1'b1;
				{rc_r, byte_r} <= 8'h00;
			end else if (scl && scl_r && !sda_r && sda) begin // Stop ends the frame
				frm_r <= 1'b0;
			end else if (scl && !scl_r) begin // Rising clock
				rc_r <= (rc_r == 4'h9) ? 4'h1 : rc_r + 4'h1;
				if (rc_r == 4'h9) byte_r <= byte_r + 4'h1;
				if (rc_r != 4'h8) sh_r <= {sh_r[6:0], sda};
				if (rc_r == 4'h7 && byte_r == 4'h0) dir_r <= sda;
			end
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Start, then the slave stays off the line
	sequence start_s;
		scl && $fell(sda);
	endsequence
	// Acknowledge held for eight system clocks
	sequence ack_s;
		oe_r [*8];
	endsequence
	slave_low_only_a: assert property (sda_s_oe |-> !sda_s_o && !sda)
		else $error("slave drives data high");
	slave_edge_a: assert property ($changed(sda_s_oe) |-> !scl)
		else $error("slave changed data with clock high");
	addr_ack_a: assert property (byte_r == 4'h0 && ack8 && match |-> oe_r)
		else $error("own address not acknowledged");
	addr_quiet_a: assert property (byte_r == 4'h0 && ack8 && !match |-> !oe_r)
		else $error("foreign address acknowledged");
	write_drive_a: assert property (!dir_r && oe_r |-> ack8 || rc_r == 4'h9)
		else $error("slave drove outside acknowledge slot");
	ack_hold_a: assert property ($rose(oe_r) && !dir_r |-> ack_s)
		else $error("acknowledge too short");
	read_release_a: assert property (dir_r && byte_r != 4'h0 && ack8 |-> !oe_r)
		else $error("slave held data after read byte");
	idle_quiet_a: assert property (!frm_r |-> !oe_r)
		else $error("slave drove between frames");
	start_quiet_a: assert property (start_s |-> !sda_s_oe [*8])
		else $error("slave drove right after start");
endmodule : tws_monitor

// File: tb/tb_top.sv
// Self-checking bench joining the two-wire host and slave ends.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_top import tws_pkg::*;;
	logic clk; // System clock
	logic nrst; // Reset, active low
	logic ce; // Enable, tied high
	logic adc_start; // Strap conversion request
	logic adc_done; // Strap conversion done
	logic [7:0] adc_code; // Strap code
	logic [2:0] addr_low; // Captured address bits
	logic [7:0] reg_ptr; // Slave pointer
	logic wr_stb; // Register write pulse
	logic [7:0] wr_data; // Register write data
	logic [7:0] rd_data; // Pointed register
	logic cmd_valid, cmd_ready, cmd_rd, cmd_two; // Host command handshake
	logic [6:0] cmd_addr; // Slave address
	logic [7:0] cmd_ptr, cmd_data; // Pointer and data bytes
	logic rsp_valid, rsp_nack; // Completion
	logic [7:0] rsp_data; // Read byte
	logic [2:0] hs; // Signals waited on
	logic [7:0] mem [256]; // Register file behind the slave
	logic [7:0] exp_mem [256]; // Expected register contents
	int n_errors, checks, n_stb, seed;
	assign hs = {rsp_valid, cmd_ready, adc_start};
	assign rd_data = mem[reg_ptr];
	tws_if tws_if_inst();
	tws_host #(.QTR(4)) tws_host_inst (.clk(clk), .nrst(nrst), .ce(ce), .bus(tws_if_inst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rd(cmd_rd), .cmd_two(cmd_two),
		.cmd_addr(cmd_addr), .cmd_ptr(cmd_ptr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_nack(rsp_nack));
	tws_slave tws_slave_inst (.clk(clk), .nrst(nrst), .ce(ce), .bus(tws_if_inst),
		.adc_start(adc_start), .adc_done(adc_done), .adc_code(adc_code),
		.addr_low(addr_low), .reg_ptr(reg_ptr), .wr_stb(wr_stb), .wr_data(wr_data),
		.rd_data(rd_data));
	tws_monitor tws_monitor_inst (.clk(clk), .nrst(nrst), .scl(tws_if_inst.scl),
		.sda(tws_if_inst.sda), .sda_s_o(tws_if_inst.sda_s_o),
		.sda_s_oe(tws_if_inst.sda_s_oe), .addr_low(addr_low));
	// Clock at 50 ns
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Register file takes slave writes
	always @(posedge clk) begin
		if (wr_stb === 1'b1) begin
			mem[reg_ptr] <= wr_data;
			n_stb <= n_stb + 1;
		end
	end
	// Expected address low bits for a strap code
	function automatic logic [2:0] low_of(input logic [7:0] c);
		return c[ADC_W-1 -: LOW_W];
	endfunction : low_of
	// Verdict and end of run
	task automatic end_sim;
		if (n_errors == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim
	// Bounded wait for one handshake signal
	task automatic wait_hi(input int w, input int lim);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hs[w] !== 1'b1 && k < lim);
		if (hs[w] !== 1'b1) begin
			n_errors++;
			end_sim();
		end
	endtask : wait_hi
	// One host operation, start to completion
	task automatic op(input logic rd, two, input logic [6:0] a, input logic [7:0] p, d);
		{cmd_rd, cmd_two, cmd_addr, cmd_ptr, cmd_data} = {rd, two, a, p, d};
		cmd_valid = 1'b1;
		wait_hi(1, 100);
		#2 cmd_valid = 1'b0;
		wait_hi(2, 4000);
		#2;
	endtask : op
	// Reset, strap capture, then foreign addresses
	task automatic power_up(input logic [7:0] code);
		nrst = 1'b0;
		repeat (3) @(posedge clk);
		#2 nrst = 1'b1;
		adc_code = code;
		wait_hi(0, 20);
		#2 adc_done = 1'b1;
		@(posedge clk);
		#2 adc_done = 1'b0;
		adc_code = ~code;
		repeat (4) @(posedge clk);
		`CHK("addr_low", low_of(code), addr_low)
		#2 adc_done = 1'b1;
		@(posedge clk);
		#2 adc_done = 1'b0;
		repeat (4) @(posedge clk);
		`CHK("addr_low held", low_of(code), addr_low)
		#2 op(1'b0, 1'b0, {4'h4, low_of(code)}, 8'h00, 8'h00);
		`CHK("upper nibble nack", 1'b1, rsp_nack)
		op(1'b0, 1'b0, {ADDR_HI, ~low_of(code)}, 8'h00, 8'h00);
		`CHK("low bits nack", 1'b1, rsp_nack)
		`CHK("reg_ptr reset", PTR_RST, reg_ptr)
	endtask : power_up
	// Main sequence
	initial begin
		logic [7:0] code, p, d, q;
		logic [6:0] me;
		int n;
		{nrst, ce, adc_done, adc_code, cmd_valid} = {3'b010, 8'h00, 1'b0};
		{cmd_rd, cmd_two, cmd_addr, cmd_ptr, cmd_data} = 25'h0;
		{n_errors, checks, n_stb} = 96'h0;
		seed = 32'h594FF943;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'($random(seed));
			exp_mem[i] = mem[i];
		end
		for (int r = 0; r < 3; r++) begin
			code = (r == 0) ? 8'($random(seed)) : ((r == 1) ? 8'hFF : 8'h00);
			power_up(code);
			me = {ADDR_HI, low_of(code)};
			op(1'b1, 1'b0, me, 8'h00, 8'h00);
			`CHK("read after reset", exp_mem[PTR_RST], rsp_data)
			for (int j = 0; j < 4; j++) begin
				p = (j == 0) ? 8'hFF : 8'($random(seed));
				d = 8'($random(seed));
				q = 8'($random(seed));
				op(1'b0, 1'b1, me, p, d);
				exp_mem[p] = d;
				`CHK("write nack", 1'b0, rsp_nack)
				`CHK("reg_ptr", p, reg_ptr)
				`CHK("stored data", d, mem[p])
				n = n_stb;
				op(1'b0, 1'b0, me, q, 8'h00);
				`CHK("pointer only", q, reg_ptr)
				`CHK("write strobes", n, n_stb)
				op(1'b1, 1'b0, me, 8'h00, 8'h00);
				`CHK("read data", exp_mem[q], rsp_data)
				`CHK("pointer kept", q, reg_ptr)
				op(1'b0, 1'b0, me, p, 8'h00);
				op(1'b1, 1'b0, me, 8'h00, 8'h00);
				`CHK("reread", d, rsp_data)
			end
		end
		end_sim();
	end
endmodule : tb_top
